//--- hw/bstap_pkg.sv
package bstap_pkg;

	// ----------------------------------------
	// instruction codes, lsb first
	// ----------------------------------------
	localparam int IR_W = 3;
	localparam logic [2:0] INS_EXTEST = 3'h0;
	localparam logic [2:0] INS_IDENT = 3'h1;
	localparam logic [2:0] INS_SAMPZ = 3'h2;
	localparam logic [2:0] INS_SAMPLE = 3'h4;
	localparam logic [2:0] INS_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	localparam int IR_MSB = 2;
	localparam int IR_LSB = 0;

	// ----------------------------------------
	// identification value, arbitrary
	// ----------------------------------------
	localparam logic [31:0] ID_VALUE = 32'h1234_5679;
	localparam int ID_W = 32;

	// ----------------------------------------
	// controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SELDR = 4'h2, ST_CAPDR = 4'h3,
		ST_SHDR = 4'h4, ST_EX1DR = 4'h5, ST_PDR = 4'h6, ST_EX2DR = 4'h7,
		ST_UPDR = 4'h8, ST_SELIR = 4'h9, ST_CAPIR = 4'hA, ST_SHIR = 4'hB,
		ST_EX1IR = 4'hC, ST_PIR = 4'hD, ST_EX2IR = 4'hE, ST_UPIR = 4'hF
	} bstap_state_type;

	// ----------------------------------------
	// serial link bundles
	// ----------------------------------------
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} bstap_link_type;

	typedef struct packed {
		logic tdo;
		logic tdoEn;
	} bstap_tdo_type;

endpackage

//--- hw/bstap_top.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// small fifo for captured pad words
// ----------------------------------------
module bstap_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic doWr, doRd;
	assign inReady = (cnt_r != (AW+1)'(DEPTH));
	assign outValid = (cnt_r != '0);
	assign outData = mem[rp_r];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	always_comb begin
		wp_nxt = doWr ? wp_r + AW'(1) : wp_r;
		rp_nxt = doRd ? rp_r + AW'(1) : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(doWr) - (AW+1)'(doRd);
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		if (doWr) begin
			mem[wp_r] <= inData;
		end
	end
endmodule

module bstap_top
	import bstap_pkg::*;
#(
	parameter int IN_W = 8,
	parameter int OUT_W = 8,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire bstap_link_type linkIn,
	input wire logic tmsDriven,
	input wire logic tdiDriven,
	output bstap_tdo_type tdoOut,
	input wire logic [IN_W-1:0] padIn,
	input wire logic [OUT_W-1:0] readData,
	output logic [OUT_W-1:0] qOut,
	output logic qOutEn,
	output logic [IN_W+OUT_W-1:0] capWord,
	output logic capValid,
	input wire logic capReady
);
	localparam int BSR_W = IN_W + OUT_W;

	// ----------------------------------------
	// pin synchronisers and edge find
	// ----------------------------------------
	logic [4:0] s1_r, s2_r, s1_nxt, s2_nxt;
	logic tckOld_r, tckOld_nxt;
	logic [IN_W+OUT_W-1:0] pad1_r, pad2_r;
	logic tck, tms, tdi, rise, fall;

	always_comb begin
		s1_nxt = {linkIn.tck, linkIn.tms, linkIn.tdi, tmsDriven, tdiDriven};
		s2_nxt = s1_r;
		tckOld_nxt = s2_r[4];
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s1_r <= 5'h0F;
			s2_r <= 5'h0F;
			tckOld_r <= 1'b0;
			pad1_r <= '0;
			pad2_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			tckOld_r <= tckOld_nxt;
			pad1_r <= {padIn, readData};
			pad2_r <= pad1_r;
		end
	end
	assign tck = s2_r[4];
	assign tms = s2_r[3] | ~s2_r[1];
	assign tdi = s2_r[2] | ~s2_r[0];
	assign rise = tck & ~tckOld_r;
	assign fall = ~tck & tckOld_r;
	// ----------------------------------------
	// controller and registers
	// ----------------------------------------
	bstap_state_type st_r, st_nxt;
	logic [IR_W-1:0] irSh_r, irSh_nxt, ir_r, ir_nxt;
	logic [ID_W-1:0] idSh_r, idSh_nxt;
	logic byp_r, byp_nxt;
	logic [BSR_W-1:0] bsr_r, bsr_nxt, upd_r, upd_nxt;
	logic tdo_r, tdo_nxt, tdoEn_r, tdoEn_nxt;
	logic [OUT_W-1:0] q_r, q_nxt;
	logic qEn_r, qEn_nxt, push;
	logic selId, selBsr, selByp;

	always_comb begin
		unique case (ir_r)
			INS_IDENT: {selId, selBsr, selByp} = 3'h4;
			INS_EXTEST, INS_SAMPZ, INS_SAMPLE: {selId, selBsr, selByp} = 3'h2;
			default: {selId, selBsr, selByp} = 3'h1;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		if (rise) begin
			unique case (st_r)
				ST_TLR: st_nxt = tms ? ST_TLR : ST_RTI;
				ST_RTI: st_nxt = tms ? ST_SELDR : ST_RTI;
				ST_SELDR: st_nxt = tms ? ST_SELIR : ST_CAPDR;
				ST_CAPDR: st_nxt = tms ? ST_EX1DR : ST_SHDR;
				ST_SHDR: st_nxt = tms ? ST_EX1DR : ST_SHDR;
				ST_EX1DR: st_nxt = tms ? ST_UPDR : ST_PDR;
				ST_PDR: st_nxt = tms ? ST_EX2DR : ST_PDR;
				ST_EX2DR: st_nxt = tms ? ST_UPDR : ST_SHDR;
				ST_UPDR: st_nxt = tms ? ST_SELDR : ST_RTI;
				ST_SELIR: st_nxt = tms ? ST_TLR : ST_CAPIR;
				ST_CAPIR: st_nxt = tms ? ST_EX1IR : ST_SHIR;
				ST_SHIR: st_nxt = tms ? ST_EX1IR : ST_SHIR;
				ST_EX1IR: st_nxt = tms ? ST_UPIR : ST_PIR;
				ST_PIR: st_nxt = tms ? ST_EX2IR : ST_PIR;
				ST_EX2IR: st_nxt = tms ? ST_UPIR : ST_SHIR;
				ST_UPIR: st_nxt = tms ? ST_SELDR : ST_RTI;
			endcase
		end
	end

	always_comb begin
		irSh_nxt = irSh_r;
		ir_nxt = ir_r;
		idSh_nxt = idSh_r;
		byp_nxt = byp_r;
		bsr_nxt = bsr_r;
		upd_nxt = upd_r;
		push = 1'b0;
		if (rise) begin
			unique case (st_r)
				ST_CAPIR: irSh_nxt = IR_CAPTURE;
				ST_SHIR: irSh_nxt = {tdi, irSh_r[IR_MSB:IR_LSB+1]};
				ST_UPIR: ir_nxt = irSh_r;
				ST_CAPDR: begin
					if (selId) idSh_nxt = ID_VALUE;
					if (selByp) byp_nxt = 1'b0;
					if (selBsr) begin
						bsr_nxt = pad2_r;
						push = 1'b1;
					end
				end
				ST_SHDR: begin
					if (selId) idSh_nxt = {tdi, idSh_r[ID_W-1:1]};
					if (selByp) byp_nxt = tdi;
					if (selBsr) bsr_nxt = {tdi, bsr_r[BSR_W-1:1]};
				end
				ST_UPDR: if (selBsr) upd_nxt = bsr_r;
				default: ;
			endcase
		end
		if (rise && st_nxt == ST_TLR) ir_nxt = INS_IDENT;
	end

	always_comb begin
		tdo_nxt = tdo_r;
		tdoEn_nxt = tdoEn_r;
		if (fall) begin
			tdoEn_nxt = (st_r == ST_SHDR) || (st_r == ST_SHIR);
			if (st_r == ST_SHIR) tdo_nxt = irSh_r[0];
			else if (selId) tdo_nxt = idSh_r[0];
			else if (selBsr) tdo_nxt = bsr_r[0];
			else tdo_nxt = byp_r;
		end
		// read-data path follows memory unless EXTEST owns it; SAMPZ only drops its enable
		unique case (ir_r)
			INS_SAMPZ: begin
				q_nxt = readData;
				qEn_nxt = 1'b0;
			end
			INS_EXTEST: begin
				q_nxt = upd_r[OUT_W-1:0];
				qEn_nxt = 1'b1;
			end
			default: begin
				q_nxt = readData;
				qEn_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_r <= ST_TLR;
			irSh_r <= IR_CAPTURE;
			ir_r <= INS_IDENT;
			idSh_r <= '0;
			byp_r <= 1'b0;
			bsr_r <= '0;
			upd_r <= '0;
			tdo_r <= 1'b0;
			tdoEn_r <= 1'b0;
			q_r <= '0;
			qEn_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			irSh_r <= irSh_nxt;
			ir_r <= ir_nxt;
			idSh_r <= idSh_nxt;
			byp_r <= byp_nxt;
			bsr_r <= bsr_nxt;
			upd_r <= upd_nxt;
			tdo_r <= tdo_nxt;
			tdoEn_r <= tdoEn_nxt;
			q_r <= q_nxt;
			qEn_r <= qEn_nxt;
		end
	end

	// ----------------------------------------
	// captured words to the side port
	// ----------------------------------------
	logic fVal, fReady;
	logic [BSR_W-1:0] fData;
	logic [BSR_W-1:0] cw_r, cw_nxt;
	logic cv_r, cv_nxt;
	bstap_fifo #(.WIDTH(BSR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.inValid(push),
		.inReady(),
		.inData(bsr_nxt),
		.outValid(fVal),
		.outReady(fReady),
		.outData(fData)
	);
	assign fReady = !cv_r || capReady;
	always_comb begin
		cw_nxt = cw_r;
		cv_nxt = cv_r;
		if (fReady) begin
			cv_nxt = fVal;
			if (fVal) cw_nxt = fData;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cw_r <= '0;
			cv_r <= 1'b0;
		end else begin
			cw_r <= cw_nxt;
			cv_r <= cv_nxt;
		end
	end
	assign tdoOut = '{tdo: tdo_r, tdoEn: tdoEn_r};
	assign qOut = q_r;
	assign qOutEn = qEn_r;
	assign capWord = cw_r;
	assign capValid = cv_r;
endmodule

`default_nettype wire

//--- sim/bstap_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module bstap_top_asserts
	import bstap_pkg::*;
#(
	parameter int IN_W = 8,
	parameter int OUT_W = 8,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire bstap_link_type linkIn,
	input wire logic tmsDriven,
	input wire logic tdiDriven,
	input wire bstap_tdo_type tdoOut,
	input wire logic [IN_W-1:0] padIn,
	input wire logic [OUT_W-1:0] readData,
	input wire logic [OUT_W-1:0] qOut,
	input wire logic qOutEn,
	input wire logic [IN_W+OUT_W-1:0] capWord,
	input wire logic capValid,
	input wire logic capReady
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_tdo_on_fall: assert property ($changed(tdoOut) |-> !$past(linkIn.tck, 2))
		else $error("tdo moved off falling tck");
	a_tdo_en_hold: assert property ($rose(tdoOut.tdoEn) |=> tdoOut.tdoEn [*6])
		else $error("tdo enable too short");
	a_idle_quiet: assert property (!linkIn.tck [*8] |=> $stable(tdoOut) && $stable(qOutEn))
		else $error("port moved with tck idle");
	a_qoff_rise: assert property ($fell(qOutEn) |-> $past(linkIn.tck, 2))
		else $error("drive dropped off rising tck");
	a_qen_release: assert property ($rose(reset_n) |=> qOutEn)
		else $error("no drive after reset");
	a_reset_clear: assert property (disable iff (1'b0) !reset_n |=> !tdoOut.tdoEn && !capValid && !qOutEn)
		else $error("reset did not clear");
	a_cap_hold: assert property (capValid && !capReady |=> capValid && $stable(capWord))
		else $error("capture word not held");
	a_cap_release: assert property ($fell(capValid) |-> $past(capReady))
		else $error("capture lost unread");
endmodule
bind bstap_top bstap_top_asserts #(.IN_W(IN_W), .OUT_W(OUT_W), .FIFO_DEPTH(FIFO_DEPTH)) i_asserts (.*);
`default_nettype wire

//--- sim/bstap_jtag_host.sv
`timescale 1ns/1ns
`default_nettype none
module bstap_jtag_host
	import bstap_pkg::*;
(
	input wire logic clk_sys,
	input wire bstap_tdo_type tdoOut,
	output bstap_link_type linkIn,
	output logic tmsDriven,
	output logic tdiDriven
);
	logic tck;
	logic tms;
	logic tdi;
	logic junk;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		junk = 1'b0;
		tmsDriven = 1'b1;
		tdiDriven = 1'b1;
	end
	// ----------------------------------------
	// released pins show a changing pattern
	// ----------------------------------------
	always @(posedge clk_sys) junk <= #1 ~junk;
	assign linkIn = '{tck, tmsDriven ? tms : junk, tdiDriven ? tdi : junk};
	// one tck period, pins change at falling tck
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		repeat (4) @(posedge clk_sys);
		#1 tck = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 q = tdoOut.tdo;
		repeat (2) @(posedge clk_sys);
		#1 tck = 1'b0;
	endtask
	task automatic reset_tap();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
	// from idle through capture, shift and update back to idle
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import bstap_pkg::*;
;
	logic clk_sys;
	logic reset_n;
	bstap_link_type linkIn;
	logic tmsDriven;
	logic tdiDriven;
	bstap_tdo_type tdoOut;
	logic [7:0] padIn;
	logic [7:0] readData;
	logic [7:0] qOut;
	logic qOutEn;
	logic [15:0] capWord;
	logic capValid;
	logic capReady;
	logic q;
	logic [63:0] r;
	int err_total;
	int total_checks;
	bstap_top i_bstap_top (.*);
	bstap_jtag_host i_host (.*);
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic load_ir(input logic [2:0] c);
		i_host.scan(1'b1, 3, {61'h0, c}, r);
		chk("ir capture", 64'h1, r);
	endtask
	task automatic t_ident();
		i_host.step(1'b0, 1'b1, q);
		i_host.scan(1'b0, 32, 64'h0, r);
		chk("id", {32'h0, ID_VALUE}, r);
		chk("tdo off", 64'h0, {63'h0, tdoOut.tdoEn});
	endtask
	task automatic t_sample(input logic [2:0] c, input logic en);
		padIn = 8'h3C;
		readData = 8'hC5;
		load_ir(c);
		chk("qen", {63'h0, en}, {63'h0, qOutEn});
		if (en) chk("qout", 64'hC5, {56'h0, qOut});
		i_host.scan(1'b0, 16, 64'h0, r);
		chk("bsr", 64'h3CC5, r);
	endtask
	task automatic t_bypass();
		logic [2:0] codes [4] = '{INS_BYPASS, 3'h3, 3'h5, 3'h6};
		foreach (codes[k]) begin
			load_ir(codes[k]);
			i_host.scan(1'b0, 33, 64'hA5C3_5A3C, r);
			chk("bypass", 64'h1_4B86_B478, r);
			chk("qen", 64'h1, {63'h0, qOutEn});
			chk("qout", 64'hC5, {56'h0, qOut});
		end
	endtask
	task automatic t_fifo();
		int n;
		capReady = 1'b0;
		load_ir(INS_SAMPLE);
		for (int k = 0; k < 6; k++) begin
			padIn = 8'(k);
			i_host.scan(1'b0, 16, 64'h0, r);
		end
		for (int k = 0; k < 5; k++) begin
			n = 0;
			while (capValid !== 1'b1 && n < 20) begin
				@(posedge clk_sys);
				#1 n++;
			end
			chk("capword", {48'h0, 8'(k), 8'hC5}, {48'h0, capWord});
			capReady = 1'b1;
			@(posedge clk_sys);
			#1 capReady = 1'b0;
		end
		repeat (3) @(posedge clk_sys);
		#1 chk("cap empty", 64'h0, {63'h0, capValid});
		capReady = 1'b1;
	endtask
	task automatic t_extest();
		padIn = 8'h96;
		load_ir(INS_SAMPLE);
		i_host.scan(1'b0, 16, 64'h5AA5, r);
		chk("bsr preload", 64'h96C5, r);
		load_ir(INS_EXTEST);
		chk("qen extest", 64'h1, {63'h0, qOutEn});
		chk("qout extest", 64'hA5, {56'h0, qOut});
	endtask
	task automatic t_float();
		load_ir(INS_BYPASS);
		i_host.tmsDriven = 1'b0;
		repeat (5) i_host.step(1'b0, 1'b0, q);
		i_host.tmsDriven = 1'b1;
		i_host.step(1'b0, 1'b1, q);
		i_host.scan(1'b0, 32, 64'h0, r);
		chk("id tlr", {32'h0, ID_VALUE}, r);
		load_ir(INS_BYPASS);
		i_host.tdiDriven = 1'b0;
		i_host.scan(1'b0, 4, 64'h0, r);
		chk("tdi float", 64'hE, r);
		i_host.tdiDriven = 1'b1;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		reset_n = 1'b0;
		padIn = 8'h00;
		readData = 8'h00;
		capReady = 1'b1;
		err_total = 0;
		total_checks = 0;
		repeat (6) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 t_ident();
		t_sample(INS_SAMPLE, 1'b1);
		t_sample(INS_SAMPZ, 1'b0);
		t_bypass();
		t_fifo();
		t_extest();
		t_float();
		print_verdict();
	end
	initial begin
		#2_000_000;
		err_total++;
		print_verdict();
	end
endmodule
`default_nettype wire
